// file: host_pin_model.sv
// Purpose: Host side of one interrupt wire with a pull-up and optional drive.
// Assumes: The host may drive while the device drives; the device drive then wins.
// Notes: A released wire reads high, never the last driven value.
`timescale 1ns/1ps
module host_pin_model (
  input wire logic oe,
  input wire logic out,
  input wire logic ext_en,
  input wire logic ext_val,
  output logic lvl
);
  // Device drive wins, then the host drive, then the board pull-up.
  assign lvl = oe ? out : (ext_en ? ext_val : 1'b1);
endmodule

// file: irq_ctrl_pkg.sv
// Purpose: Shared constants and state types for the interrupt enable and pin control block.
// Assumes: Eight-bit register port, one clock, synchronous active-low reset.
// Notes: Reserved register bits are masked on write and read back as zero.
package irq_ctrl_pkg;

  // Register offsets on the host register port.
  localparam logic [7:0] ADDR_EN_MOTION = 8'h50;
  localparam logic [7:0] ADDR_EN_FIFO = 8'h51;
  localparam logic [7:0] ADDR_EN_STEP = 8'h52;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h53;
  localparam logic [7:0] ADDR_LATCH = 8'h54;
  localparam logic [7:0] ADDR_MAP_A = 8'h55;
  localparam logic [7:0] ADDR_MAP_MIX = 8'h56;
  localparam logic [7:0] ADDR_MAP_B = 8'h57;

  // Reset values; every register in this block clears to zero.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Writable-bit masks; reserved positions stay zero.
  localparam logic [7:0] MASK_EN_MOTION = 8'hF7;
  localparam logic [7:0] MASK_EN_FIFO = 8'h7F;
  localparam logic [7:0] MASK_EN_STEP = 8'h0F;
  localparam logic [7:0] MASK_LATCH = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // Field positions of the first enable byte.
  localparam int EN0_FLAT = 7;
  localparam int EN0_ORIENT = 6;
  localparam int EN0_S_TAP = 5;
  localparam int EN0_D_TAP = 4;
  // Field positions of the second enable byte.
  localparam int EN1_FWM = 6;
  localparam int EN1_FFULL = 5;
  localparam int EN1_DRDY = 4;
  localparam int EN1_LOW = 3;
  // Field position of the step detector in the third enable byte.
  localparam int EN2_STEP = 3;

  // Field positions of the pin output control byte.
  localparam int OC_B_DRIVE = 7;
  localparam int OC_B_OD = 6;
  localparam int OC_B_POL = 5;
  localparam int OC_B_EDGE = 4;
  localparam int OC_A_DRIVE = 3;
  localparam int OC_A_OD = 2;
  localparam int OC_A_POL = 1;
  localparam int OC_A_EDGE = 0;

  // Field positions of the latch register.
  localparam int LATCH_B_IN = 5;
  localparam int LATCH_A_IN = 4;

  // Interrupt source indices, in the order of the mapping bytes.
  localparam int SRC_LOW_STEP = 0;
  localparam int SRC_HIGH = 1;
  localparam int SRC_ANYMO = 2;
  localparam int SRC_NOMO = 3;
  localparam int SRC_D_TAP = 4;
  localparam int SRC_S_TAP = 5;
  localparam int SRC_ORIENT = 6;
  localparam int SRC_FLAT = 7;
  localparam int SRC_PMU = 8;
  localparam int SRC_FFULL = 9;
  localparam int SRC_FWM = 10;
  localparam int SRC_DRDY = 11;
  localparam int NUM_SRC = 12;
  localparam int NUM_PINS = 2;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;

  // State of one pin driver.
  typedef struct packed {
    logic prev_active;
    logic trig;
    logic tag;
    logic out;
    logic oe;
  } pin_state_t;

  // State of the register file.
  typedef struct packed {
    logic [7:0] en_motion;
    logic [7:0] en_fifo;
    logic [7:0] en_step;
    logic [7:0] out_ctrl;
    logic [7:0] latch;
    logic [7:0] map_a;
    logic [7:0] map_mix;
    logic [7:0] map_b;
    logic [7:0] rdata;
    logic rvalid;
  } ctrl_state_t;

endpackage

// file: irq_enable_pin_ctrl.sv
// Purpose: Interrupt engine enables, interrupt-to-pin routing and pin electrical control.
// Assumes: Register port strobes and pin inputs are synchronous to core_clk.
// Notes: Reserved bits are dropped on write; unmapped reads return zero.
// How it works
// - Each engine runs only while its enable bit is one; enables clear at reset.
// - First enable byte: flat, orientation, single tap, double tap, any-motion z y x.
// - Second enable byte: watermark, full, data ready, low, high z y x.
// - Third enable byte: step detector and no-motion z y x; upper nibble reserved.
// - Control bit 7 turns the second pin's output driver on or off.
// - Control bit 6 picks open drain or push pull for the second pin.
// - Control bit 5 sets the second pin's active level, output or trigger input.
// - Control bit 4 picks edge or level sensing on the second pin.
// - Control bit 3 turns the first pin's output driver on or off.
// - Control bit 2 picks open drain or push pull for the first pin.
// - Control bit 1 sets the first pin's active level, output or trigger input.
// - Control bit 0 picks edge or level sensing on the first pin.
// - Edge or level choice only matters while the pin serves as input.
// - Frame tagging through a pin ignores that pin's active level.
// - Pin control byte resets to zero: outputs off, push pull, low, level.
// - Latch bits five and four enable the second and first pin as inputs.
// - Mapping bits route each interrupt to a pin; one means routed.
`timescale 1ns/1ps
module irq_enable_pin_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] irq_src,
  output logic [23:0] engine_run,
  output logic [3:0] latch_mode,
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  input wire logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic power_trigger_a,
  output logic power_trigger_b,
  output logic queue_mark_via_pin_a,
  output logic queue_mark_via_pin_b
);
  import irq_ctrl_pkg::*;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;
  logic [NUM_SRC-1:0] src_enable;
  logic [NUM_SRC-1:0] src_gated;
  logic [NUM_SRC-1:0] route_a;
  logic [NUM_SRC-1:0] route_b;
  logic [NUM_PINS-1:0] pin_in_vec;
  logic [NUM_PINS-1:0] pin_out_vec;
  logic [NUM_PINS-1:0] pin_oe_vec;

  pin_ctrl_if pin_if [NUM_PINS] ();

  // Register file: host writes and registered reads.
  // Reserved bits are masked here so the stored value always reads back clean,
  // which spares every consumer from masking again.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = reg_rd;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_EN_MOTION: begin
          nxt_st.en_motion = reg_wdata & MASK_EN_MOTION;
        end
        ADDR_EN_FIFO: begin
          nxt_st.en_fifo = reg_wdata & MASK_EN_FIFO;
        end
        ADDR_EN_STEP: begin
          nxt_st.en_step = reg_wdata & MASK_EN_STEP;
        end
        ADDR_OUT_CTRL: begin
          nxt_st.out_ctrl = reg_wdata & MASK_FULL;
        end
        ADDR_LATCH: begin
          nxt_st.latch = reg_wdata & MASK_LATCH;
        end
        ADDR_MAP_A: begin
          nxt_st.map_a = reg_wdata;
        end
        ADDR_MAP_MIX: begin
          nxt_st.map_mix = reg_wdata;
        end
        ADDR_MAP_B: begin
          nxt_st.map_b = reg_wdata;
        end
        default: begin
          // Writes to other addresses belong to other blocks and are ignored.
        end
      endcase
    end
    // Reads return the stored byte, including a same-cycle write's old value.
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_EN_MOTION: begin
          nxt_st.rdata = st_ff.en_motion;
        end
        ADDR_EN_FIFO: begin
          nxt_st.rdata = st_ff.en_fifo;
        end
        ADDR_EN_STEP: begin
          nxt_st.rdata = st_ff.en_step;
        end
        ADDR_OUT_CTRL: begin
          nxt_st.rdata = st_ff.out_ctrl;
        end
        ADDR_LATCH: begin
          nxt_st.rdata = st_ff.latch;
        end
        ADDR_MAP_A: begin
          nxt_st.rdata = st_ff.map_a;
        end
        ADDR_MAP_MIX: begin
          nxt_st.rdata = st_ff.map_mix;
        end
        ADDR_MAP_B: begin
          nxt_st.rdata = st_ff.map_b;
        end
        default: begin
          nxt_st.rdata = RST_BYTE;
        end
      endcase
    end
  end

  // Every register clears at reset, so all engines are off and both pins float.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff.en_motion <= RST_BYTE;
      st_ff.en_fifo <= RST_BYTE;
      st_ff.en_step <= RST_BYTE;
      st_ff.out_ctrl <= RST_BYTE;
      st_ff.latch <= RST_BYTE;
      st_ff.map_a <= RST_BYTE;
      st_ff.map_mix <= RST_BYTE;
      st_ff.map_b <= RST_BYTE;
      st_ff.rdata <= RST_BYTE;
      st_ff.rvalid <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign latch_mode = st_ff.latch[3:0];

  // Engine run lines come straight from the enable flops, in register order.
  assign engine_run = {st_ff.en_step, st_ff.en_fifo, st_ff.en_motion};

  // An engine's result counts only while that engine is switched on.
  // Engines with per-axis enables run while any of their axes is on.
  always_comb begin
    src_enable = '0;
    src_enable[SRC_LOW_STEP] = st_ff.en_fifo[EN1_LOW] | st_ff.en_step[EN2_STEP];
    src_enable[SRC_HIGH] = |st_ff.en_fifo[2:0];
    src_enable[SRC_ANYMO] = |st_ff.en_motion[2:0];
    src_enable[SRC_NOMO] = |st_ff.en_step[2:0];
    src_enable[SRC_D_TAP] = st_ff.en_motion[EN0_D_TAP];
    src_enable[SRC_S_TAP] = st_ff.en_motion[EN0_S_TAP];
    src_enable[SRC_ORIENT] = st_ff.en_motion[EN0_ORIENT];
    src_enable[SRC_FLAT] = st_ff.en_motion[EN0_FLAT];
    // The power trigger has no engine enable of its own.
    src_enable[SRC_PMU] = 1'b1;
    src_enable[SRC_FFULL] = st_ff.en_fifo[EN1_FFULL];
    src_enable[SRC_FWM] = st_ff.en_fifo[EN1_FWM];
    src_enable[SRC_DRDY] = st_ff.en_fifo[EN1_DRDY];
  end

  assign src_gated = irq_src & src_enable;

  // Routing: the shared mapping byte holds the data-driven sources for both pins.
  assign route_a = {st_ff.map_mix[7:4], st_ff.map_a};
  assign route_b = {st_ff.map_mix[3:0], st_ff.map_b};

  // Pin A configuration from the low nibble of the control byte.
  assign pin_if[PIN_A].drive_on = st_ff.out_ctrl[OC_A_DRIVE];
  assign pin_if[PIN_A].open_drain = st_ff.out_ctrl[OC_A_OD];
  assign pin_if[PIN_A].polarity = st_ff.out_ctrl[OC_A_POL];
  assign pin_if[PIN_A].edge_sense = st_ff.out_ctrl[OC_A_EDGE];
  assign pin_if[PIN_A].input_en = st_ff.latch[LATCH_A_IN];
  assign pin_if[PIN_A].assert_req = |(src_gated & route_a);

  // Pin B configuration from the high nibble of the control byte.
  assign pin_if[PIN_B].drive_on = st_ff.out_ctrl[OC_B_DRIVE];
  assign pin_if[PIN_B].open_drain = st_ff.out_ctrl[OC_B_OD];
  assign pin_if[PIN_B].polarity = st_ff.out_ctrl[OC_B_POL];
  assign pin_if[PIN_B].edge_sense = st_ff.out_ctrl[OC_B_EDGE];
  assign pin_if[PIN_B].input_en = st_ff.latch[LATCH_B_IN];
  assign pin_if[PIN_B].assert_req = |(src_gated & route_b);

  assign pin_in_vec = {pin_b_in, pin_a_in};

  // One driver per pin; a pin with both output and input enabled drives and
  // raises no trigger, though its tag still follows the pin, so a device cannot trigger itself from its own output.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      irq_pin_driver u_drv (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cfg(pin_if[gi]),
        .pin_in(pin_in_vec[gi]),
        .pin_out(pin_out_vec[gi]),
        .pin_oe(pin_oe_vec[gi])
      );
    end
  endgenerate

  assign pin_a_out = pin_out_vec[PIN_A];
  assign pin_a_oe = pin_oe_vec[PIN_A];
  assign pin_b_out = pin_out_vec[PIN_B];
  assign pin_b_oe = pin_oe_vec[PIN_B];

  // Trigger and tag results leave the block for the power unit and the queue.
  assign power_trigger_a = pin_if[PIN_A].trigger;
  assign power_trigger_b = pin_if[PIN_B].trigger;
  assign queue_mark_via_pin_a = pin_if[PIN_A].tag;
  assign queue_mark_via_pin_b = pin_if[PIN_B].tag;
endmodule

// file: irq_enable_pin_ctrl_asserts.sv
// Purpose: Port-level checks of enables, pin drive and pin sensing.
// Assumes: Writes to the control and latch bytes are seen on the register port.
// Notes: Shadows of those two bytes stand in for the hidden registers.
`timescale 1ns/1ps
module irq_ctrl_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [23:0] engine_run,
  input wire logic pin_a_in,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic power_trigger_a,
  input wire logic queue_mark_via_pin_a
);
  import irq_ctrl_pkg::*;
  logic [7:0] cfg_ff;
  logic [7:0] lat_ff;
  // Track the two bytes so that each pin check has a visible cause.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_ff <= 8'h00;
      lat_ff <= 8'h00;
    end else if (reg_wr && reg_addr == ADDR_OUT_CTRL) begin
      cfg_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_LATCH) begin
      lat_ff <= reg_wdata;
    end
  end
  // One domain, so clock and reset are given once for every check.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_edge_a;
    power_trigger_a && cfg_ff[OC_A_EDGE] && $stable(cfg_ff);
  endsequence
  chk_a_drive_off: assert property (!$past(cfg_ff[OC_A_DRIVE]) |-> !pin_a_oe)
    else $error("pin a driven while off");
  chk_b_drive_off: assert property (!$past(cfg_ff[OC_B_DRIVE]) |-> !pin_b_oe)
    else $error("pin b driven while off");
  chk_a_push_pull: assert property ($past(cfg_ff[OC_A_DRIVE]) && !$past(cfg_ff[OC_A_OD]) |-> pin_a_oe)
    else $error("pin a push pull released");
  chk_b_od_low: assert property ($past(cfg_ff[OC_B_DRIVE]) && $past(cfg_ff[OC_B_OD]) && pin_b_oe |-> !pin_b_out)
    else $error("pin b open drain drove high");
  chk_motion_en_write: assert property (reg_wr && reg_addr == ADDR_EN_MOTION |=>
    engine_run[7:0] == ($past(reg_wdata) & MASK_EN_MOTION)) else $error("motion enables wrong");
  chk_fifo_en_write: assert property (reg_wr && reg_addr == ADDR_EN_FIFO |=>
    engine_run[15:8] == ($past(reg_wdata) & MASK_EN_FIFO)) else $error("fifo enables wrong");
  chk_step_en_write: assert property (reg_wr && reg_addr == ADDR_EN_STEP |=>
    engine_run[23:16] == ($past(reg_wdata) & MASK_EN_STEP)) else $error("step enables wrong");
  chk_trig_driving: assert property ($past(cfg_ff[OC_A_DRIVE]) |-> !power_trigger_a)
    else $error("trigger while pin a drives");
  chk_trig_no_input: assert property (!$past(lat_ff[LATCH_A_IN]) |-> !power_trigger_a)
    else $error("trigger with input off");
  chk_edge_one_pulse: assert property (s_edge_a |=> !power_trigger_a)
    else $error("edge trigger held high");
  chk_tag_raw_pin: assert property ($past(lat_ff[LATCH_A_IN]) && !$past(cfg_ff[OC_A_DRIVE]) |->
    queue_mark_via_pin_a == $past(pin_a_in)) else $error("tag not raw pin");
endmodule
bind irq_enable_pin_ctrl irq_ctrl_asserts u_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .engine_run, .pin_a_in, .pin_a_oe, .pin_b_out, .pin_b_oe, .power_trigger_a, .queue_mark_via_pin_a);

// file: irq_enable_pin_ctrl_bench.sv
// Purpose: Self-checking bench for enables, routing, pin drive and pin sensing.
// Assumes: Register strobes are held one cycle, then dropped for one cycle.
// Notes: A byte model of the register file predicts every pin and readback.
`timescale 1ns/1ps
module irq_enable_pin_ctrl_bench;
  import irq_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] src = 12'h000;
  logic [1:0] ext_en = 2'b00;
  logic [1:0] ext_v = 2'b00;
  logic [7:0] rdata;
  logic [23:0] run;
  logic [3:0] lm;
  logic [31:0] rv;
  logic rvalid, a_in, a_out, a_oe, b_in, b_out, b_oe, trg_a, trg_b, tag_a, tag_b;
  logic [7:0] m [8];
  logic [7:0] msk [8] = '{MASK_EN_MOTION, MASK_EN_FIFO, MASK_EN_STEP, MASK_FULL, MASK_LATCH,
    MASK_FULL, MASK_FULL, MASK_FULL};
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h5A2585EC;
  irq_enable_pin_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .irq_src(src), .engine_run(run),
    .latch_mode(lm), .pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_in(b_in),
    .pin_b_out(b_out), .pin_b_oe(b_oe), .power_trigger_a(trg_a), .power_trigger_b(trg_b),
    .queue_mark_via_pin_a(tag_a), .queue_mark_via_pin_b(tag_b));
  host_pin_model host_a (.oe(a_oe), .out(a_out), .ext_en(ext_en[0]), .ext_val(ext_v[0]), .lvl(a_in));
  host_pin_model host_b (.oe(b_oe), .out(b_out), .ext_en(ext_en[1]), .ext_val(ext_v[1]), .lvl(b_in));
  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;
  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The strobe drops for a whole cycle, so back-to-back calls never retoggle it in one step.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    if (a[7:3] == 5'h0A) m[a[2:0]] = d & msk[a[2:0]];
    tick();
  endtask
  task automatic rreg(input logic [7:0] a);
    addr = a;
    rd = 1'b1;
    tick();
    chk("rvalid", 24'h000001, {23'h0, rvalid});
    chk("rdata", {16'h0, (a[7:3] == 5'h0A) ? m[a[2:0]] : 8'h00}, {16'h0, rdata});
    rd = 1'b0;
    tick();
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) tick();
    rst_n = 1'b1;
    foreach (m[i]) m[i] = 8'h00;
  endtask
  // Predicted {oe, oe and out} of one pin from the byte model and the source levels.
  function automatic logic [1:0] exp_pin(input int p);
    logic [11:0] g;
    logic [11:0] r;
    logic [3:0] c;
    logic l;
    g = {m[1][4], m[1][6], m[1][5], 1'b1, m[0][7:4], |m[2][2:0], |m[0][2:0], |m[1][2:0], m[1][3] | m[2][3]};
    r = (p == 0) ? {m[6][7:4], m[5]} : {m[6][3:0], m[7]};
    c = (p == 0) ? m[3][3:0] : m[3][7:4];
    l = ~((|(src & g & r)) ^ c[1]);
    return !c[3] ? 2'b00 : (c[2] ? {~l, 1'b0} : {1'b1, l});
  endfunction
  task summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short; it counts as a mismatch.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("BAD watchdog expected done seen running");
    summarize();
  end
  // Main sequence: reset values, random configurations, pin sensing, mid-run reset.
  initial begin
    do_reset();
    for (int r = 0; r < 9; r++) rreg(r < 8 ? 8'h50 + r[7:0] : 8'h60);
    wreg(8'h60, 8'hFF);
    rreg(8'h60);
    for (int i = 0; i < 40; i++) begin
      for (int r = 0; r < 8; r++) begin
        rv = $random(seed);
        if (r != 4) wreg(8'h50 + r[7:0], rv[7:0]);
      end
      rv = $random(seed);
      src = rv[11:0];
      tick();
      tick();
      chk("run", {m[2], m[1], m[0]}, run);
      chk("pin_a", {22'h0, exp_pin(0)}, {22'h0, a_oe, a_oe & a_out});
      chk("pin_b", {22'h0, exp_pin(1)}, {22'h0, b_oe, b_oe & b_out});
      rreg(8'h50 + {5'h0, rv[14:12]});
    end
    wreg(ADDR_LATCH, 8'h35);
    chk("mode", {20'h0, m[4][3:0]}, {20'h0, lm});
    ext_en = 2'b11;
    for (int k = 0; k < 4; k++) begin
      wreg(ADDR_OUT_CTRL, {2'b00, k[1], k[0], 2'b00, k[1], k[0]});
      ext_v = {2{~k[1]}};
      tick();
      tick();
      chk("idle", {20'h0, {2{~k[1]}}, 2'b00}, {20'h0, tag_b, tag_a, trg_b, trg_a});
      ext_v = {2{k[1]}};
      tick();
      chk("active", {20'h0, {2{k[1]}}, 2'b11}, {20'h0, tag_b, tag_a, trg_b, trg_a});
      tick();
      chk("hold", {22'h0, {2{~k[0]}}}, {22'h0, trg_b, trg_a});
      wreg(ADDR_OUT_CTRL, {2'b10, k[1], k[0], 2'b10, k[1], k[0]});
      tick();
      chk("driving", 24'h0, {22'h0, trg_b, trg_a});
    end
    ext_en = 2'b00;
    do_reset();
    rreg(ADDR_OUT_CTRL);
    chk("released", 24'h0, {22'h0, b_oe, a_oe});
    summarize();
  end
endmodule

// file: irq_pin_driver.sv
// Purpose: Drives one interrupt pin and senses it when it serves as an input.
// Assumes: The pin input is synchronous to core_clk.
// Notes: Pin output and enable are registered, one cycle behind their cause.
`timescale 1ns/1ps
module irq_pin_driver (
  input wire logic core_clk,
  input wire logic rst_n,
  pin_ctrl_if.pin_side cfg,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  import irq_ctrl_pkg::*;

  pin_state_t st_ff;
  pin_state_t nxt_st;
  logic level;
  logic sensing;
  logic active_in;

  // Next state of the driver and of the input sensing.
  always_comb begin
    nxt_st = st_ff;
    level = cfg.polarity ? cfg.assert_req : ~cfg.assert_req;
    sensing = cfg.input_en & ~cfg.drive_on;
    active_in = cfg.polarity ? pin_in : ~pin_in;
    if (!cfg.drive_on) begin
      nxt_st.oe = 1'b0;
      nxt_st.out = 1'b0;
    end else if (cfg.open_drain) begin
      // Open drain only ever pulls low; high comes from the board.
      nxt_st.oe = ~level;
      nxt_st.out = 1'b0;
    end else begin
      nxt_st.oe = 1'b1;
      nxt_st.out = level;
    end
    // Edge mode pulses once per assertion, level mode follows the pin.
    if (!sensing) begin
      nxt_st.trig = 1'b0;
    end else if (cfg.edge_sense) begin
      nxt_st.trig = active_in & ~st_ff.prev_active;
    end else begin
      nxt_st.trig = active_in;
    end
    nxt_st.prev_active = sensing & active_in;
    // Tagging follows the raw pin so polarity cannot change it.
    nxt_st.tag = cfg.input_en & pin_in;
  end

  // All driver state clears to an undriven pin.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe = st_ff.oe;
  assign cfg.trigger = st_ff.trig;
  assign cfg.tag = st_ff.tag;
endmodule

// file: pin_ctrl_if.sv
// Purpose: Carries one pin's configuration and its detected input events.
// Assumes: Used only between the control block and its pin drivers.
// Notes: The control side owns every configuration signal.
`timescale 1ns/1ps
interface pin_ctrl_if;
  logic drive_on;
  logic open_drain;
  logic polarity;
  logic edge_sense;
  logic input_en;
  logic assert_req;
  logic trigger;
  logic tag;

  modport ctrl_side (
    output drive_on, open_drain, polarity, edge_sense, input_en, assert_req,
    input trigger, tag
  );
  modport pin_side (
    input drive_on, open_drain, polarity, edge_sense, input_en, assert_req,
    output trigger, tag
  );
endinterface
